// file: logic/evb_consts.svh
`ifndef EVB_CONSTS_SVH
`define EVB_CONSTS_SVH

// subaddresses of the register slice
`define EVB_SUB_PI12 8'h57
`define EVB_SUB_PI13 8'h58
`define EVB_SUB_PI14 8'h59
`define EVB_SUB_PHASE 8'h5A
`define EVB_SUB_UGAIN 8'h5B
`define EVB_SUB_VGAIN 8'h5C
`define EVB_SUB_UCTL 8'h5D
`define EVB_SUB_VCTL 8'h5E

// field positions inside 5DH and 5EH
`define EVB_GAIN_MSB_BIT 7
`define EVB_RT_ENABLE_BIT 6
`define EVB_LEVEL_HI 5
`define EVB_LEVEL_LO 0

// reset values, none printed for this slice
`define EVB_RST_BYTE 8'h00
`define EVB_RST_LEVEL 6'h00
`define EVB_RST_GAIN 9'h000
`define EVB_RST_BIT 1'b0
`define EVB_RST_FIELD_ODD 1'b1

// program info bytes held here, sent lsb first
`define EVB_PI_BYTES 3
`define EVB_PI_BITS 24

`endif

// file: logic/evb_pkg.sv
package evb_pkg;
	typedef logic [7:0] evb_byte_t;
	typedef logic signed [8:0] evb_gain_t;
	typedef logic [5:0] evb_level_t;
	typedef enum logic [2:0]
	{
		EVB_SER_IDLE = 3'b001,
		EVB_SER_SHIFT = 3'b010,
		EVB_SER_DONE = 3'b100
	} evb_ser_state_t;
endpackage

// file: logic/evb_line_shadow.sv
`timescale 1ns/100ps
`include "evb_consts.svh"

// holds a settings word steady for a whole line; loads only at line start
module evb_line_shadow #(
	parameter int WIDTH = 8
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic line_start,
	input wire logic [WIDTH-1:0] staged,
	output logic [WIDTH-1:0] active
);
	if (WIDTH < 1)
	begin : g_width_check
		$error("evb_line_shadow: WIDTH must be at least 1");
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			active <= '0;
		else if (line_start)
			active <= staged;
	end
endmodule

// file: logic/evb_pi_serializer.sv
`timescale 1ns/100ps
`include "evb_consts.svh"

// shifts the held program info bytes out lsb first during the line 16 window
module evb_pi_serializer #(
	parameter int BITS = `EVB_PI_BITS
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic insert_enable,
	input wire logic window_start,
	input wire logic bit_strobe,
	input wire logic [BITS-1:0] payload,
	output logic data_bit,
	output logic data_valid,
	output evb_pkg::evb_ser_state_t state
);
	import evb_pkg::*;

	logic [BITS-1:0] shifter;
	logic [$clog2(BITS+1)-1:0] count;

	if (BITS < 8 || BITS % 8 != 0)
	begin : g_bits_check
		$error("evb_pi_serializer: BITS must be a whole number of bytes");
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			state <= EVB_SER_IDLE;
			shifter <= '0;
			count <= '0;
			data_bit <= 1'b0;
			data_valid <= 1'b0;
		end
		else
		begin
			data_valid <= 1'b0;
			case (state)
				EVB_SER_IDLE:
				begin
					// payload is snapshotted so a write during the line cannot tear it
					if (window_start && insert_enable)
					begin
						shifter <= payload;
						count <= '0;
						state <= EVB_SER_SHIFT;
					end
				end
				EVB_SER_SHIFT:
				begin
					if (bit_strobe)
					begin
						data_bit <= shifter[0];
						data_valid <= 1'b1;
						shifter <= shifter >> 1;
						count <= count + 1'b1;
						if (count == ($clog2(BITS+1))'(BITS - 1))
							state <= EVB_SER_DONE;
					end
				end
				EVB_SER_DONE:
					state <= EVB_SER_IDLE;
				default:
					state <= EVB_SER_IDLE;
			endcase
		end
	end
endmodule

// file: logic/evb_regs.sv
`timescale 1ns/100ps
`include "evb_consts.svh"

module evb_regs (
	input wire logic clk,
	input wire logic reset,
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic [7:0] reg_subaddr,
	input wire logic [7:0] reg_wr_data,
	output evb_pkg::evb_byte_t reg_rd_data,
	output logic reg_rd_valid,
	output logic reg_hit,
	input wire logic program_info_insert_enable,
	input wire logic line_start,
	input wire logic field_start,
	input wire logic pi_window_start,
	input wire logic pi_bit_strobe,
	input wire logic real_time_control_input_field_valid,
	input wire logic real_time_control_input_field_odd,
	input wire logic real_time_control_input_phase_reset,
	output evb_pkg::evb_byte_t subcarrier_phase_out,
	output evb_pkg::evb_gain_t u_chroma_gain_out,
	output evb_pkg::evb_gain_t v_chroma_gain_out,
	output evb_pkg::evb_level_t black_level_out,
	output evb_pkg::evb_level_t blanking_level_out,
	output logic field_odd,
	output logic subcarrier_phase_reset,
	output logic pi_data_bit,
	output logic pi_data_valid
);
	import evb_pkg::*;

	evb_byte_t program_info_byte_12;
	evb_byte_t program_info_byte_13;
	evb_byte_t program_info_byte_14;
	evb_byte_t subcarrier_phase;
	evb_byte_t u_chroma_gain;
	evb_byte_t v_chroma_gain;
	logic u_chroma_gain_msb;
	logic v_chroma_gain_msb;
	logic rt_field_bit_enable;
	logic rt_phase_reset_enable;
	evb_level_t black_level;
	evb_level_t blanking_level;
	evb_gain_t u_gain_staged;
	evb_gain_t v_gain_staged;
	logic rt_field_active;

	function automatic logic slice_hit(input logic [7:0] sub);
		slice_hit = (sub >= `EVB_SUB_PI12) && (sub <= `EVB_SUB_VCTL);
	endfunction

	// one write strobe per subaddress
	function automatic logic write_at(
		input logic en,
		input logic [7:0] sub,
		input logic [7:0] target
	);
		write_at = en && (sub == target);
	endfunction

	// both control bytes share one layout: gain msb, real-time enable, 6-bit level
	function automatic evb_byte_t pack_ctl(
		input logic gain_msb,
		input logic rt_enable,
		input evb_level_t level
	);
		pack_ctl = {gain_msb, rt_enable, level};
	endfunction

	// the msb from the control byte is the sign of a two's complement gain
	function automatic evb_gain_t join_gain(input logic msb, input evb_byte_t low);
		join_gain = evb_gain_t'({msb, low});
	endfunction

	assign reg_hit = slice_hit(reg_subaddr);

	// program info bytes feed the read back and the serializer, which snapshots them at window start
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			program_info_byte_12 <= `EVB_RST_BYTE;
			program_info_byte_13 <= `EVB_RST_BYTE;
			program_info_byte_14 <= `EVB_RST_BYTE;
		end
		else
		begin
			if (write_at(reg_wr_en, reg_subaddr, `EVB_SUB_PI12))
				program_info_byte_12 <= reg_wr_data;
			if (write_at(reg_wr_en, reg_subaddr, `EVB_SUB_PI13))
				program_info_byte_13 <= reg_wr_data;
			if (write_at(reg_wr_en, reg_subaddr, `EVB_SUB_PI14))
				program_info_byte_14 <= reg_wr_data;
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			subcarrier_phase <= `EVB_RST_BYTE;
		else if (write_at(reg_wr_en, reg_subaddr, `EVB_SUB_PHASE))
			subcarrier_phase <= reg_wr_data;
	end

	// gain low bytes and their msbs live at different subaddresses
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			u_chroma_gain <= `EVB_RST_BYTE;
			u_chroma_gain_msb <= `EVB_RST_BIT;
		end
		else
		begin
			if (write_at(reg_wr_en, reg_subaddr, `EVB_SUB_UGAIN))
				u_chroma_gain <= reg_wr_data;
			if (write_at(reg_wr_en, reg_subaddr, `EVB_SUB_UCTL))
				u_chroma_gain_msb <= reg_wr_data[`EVB_GAIN_MSB_BIT];
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			v_chroma_gain <= `EVB_RST_BYTE;
			v_chroma_gain_msb <= `EVB_RST_BIT;
		end
		else
		begin
			if (write_at(reg_wr_en, reg_subaddr, `EVB_SUB_VGAIN))
				v_chroma_gain <= reg_wr_data;
			if (write_at(reg_wr_en, reg_subaddr, `EVB_SUB_VCTL))
				v_chroma_gain_msb <= reg_wr_data[`EVB_GAIN_MSB_BIT];
		end
	end

	// real-time control enables share their bytes with the gain msbs and levels
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			rt_field_bit_enable <= `EVB_RST_BIT;
			rt_phase_reset_enable <= `EVB_RST_BIT;
		end
		else
		begin
			if (write_at(reg_wr_en, reg_subaddr, `EVB_SUB_UCTL))
				rt_field_bit_enable <= reg_wr_data[`EVB_RT_ENABLE_BIT];
			if (write_at(reg_wr_en, reg_subaddr, `EVB_SUB_VCTL))
				rt_phase_reset_enable <= reg_wr_data[`EVB_RT_ENABLE_BIT];
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			black_level <= `EVB_RST_LEVEL;
			blanking_level <= `EVB_RST_LEVEL;
		end
		else
		begin
			if (write_at(reg_wr_en, reg_subaddr, `EVB_SUB_UCTL))
				black_level <= reg_wr_data[`EVB_LEVEL_HI:`EVB_LEVEL_LO];
			if (write_at(reg_wr_en, reg_subaddr, `EVB_SUB_VCTL))
				blanking_level <= reg_wr_data[`EVB_LEVEL_HI:`EVB_LEVEL_LO];
		end
	end

	// read back of the stored bytes; unmapped subaddresses read zero
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			reg_rd_data <= `EVB_RST_BYTE;
			reg_rd_valid <= 1'b0;
		end
		else
		begin
			reg_rd_valid <= reg_rd_en;
			if (reg_rd_en)
			begin
				case (reg_subaddr)
					`EVB_SUB_PI12: reg_rd_data <= program_info_byte_12;
					`EVB_SUB_PI13: reg_rd_data <= program_info_byte_13;
					`EVB_SUB_PI14: reg_rd_data <= program_info_byte_14;
					`EVB_SUB_PHASE: reg_rd_data <= subcarrier_phase;
					`EVB_SUB_UGAIN: reg_rd_data <= u_chroma_gain;
					`EVB_SUB_VGAIN: reg_rd_data <= v_chroma_gain;
					`EVB_SUB_UCTL:
						reg_rd_data <= pack_ctl(u_chroma_gain_msb, rt_field_bit_enable, black_level);
					`EVB_SUB_VCTL:
						reg_rd_data <= pack_ctl(v_chroma_gain_msb, rt_phase_reset_enable, blanking_level);
					default: reg_rd_data <= 8'h00;
				endcase
			end
		end
	end

	assign u_gain_staged = join_gain(u_chroma_gain_msb, u_chroma_gain);
	assign v_gain_staged = join_gain(v_chroma_gain_msb, v_chroma_gain);

	// one shadow per setting keeps a write mid-line from bending one line's colour
	evb_line_shadow #(
		.WIDTH($bits(evb_byte_t))
	) u_phase_shadow (
		.clk(clk),
		.reset(reset),
		.line_start(line_start),
		.staged(subcarrier_phase),
		.active(subcarrier_phase_out)
	);

	evb_line_shadow #(
		.WIDTH($bits(evb_gain_t))
	) u_u_gain_shadow (
		.clk(clk),
		.reset(reset),
		.line_start(line_start),
		.staged(u_gain_staged),
		.active(u_chroma_gain_out)
	);

	evb_line_shadow #(
		.WIDTH($bits(evb_gain_t))
	) u_v_gain_shadow (
		.clk(clk),
		.reset(reset),
		.line_start(line_start),
		.staged(v_gain_staged),
		.active(v_chroma_gain_out)
	);

	evb_line_shadow #(
		.WIDTH($bits(evb_level_t))
	) u_black_shadow (
		.clk(clk),
		.reset(reset),
		.line_start(line_start),
		.staged(black_level),
		.active(black_level_out)
	);

	evb_line_shadow #(
		.WIDTH($bits(evb_level_t))
	) u_blank_shadow (
		.clk(clk),
		.reset(reset),
		.line_start(line_start),
		.staged(blanking_level),
		.active(blanking_level_out)
	);

	// enable follows the line boundary like the values it qualifies
	always_ff @(posedge clk)
	begin
		if (reset)
			rt_field_active <= 1'b0;
		else if (line_start)
			rt_field_active <= rt_field_bit_enable;
	end

	// odd/even: free running toggle unless the real-time control bit is honoured
	always_ff @(posedge clk)
	begin
		if (reset)
			field_odd <= `EVB_RST_FIELD_ODD;
		else if (rt_field_active && real_time_control_input_field_valid)
			field_odd <= real_time_control_input_field_odd;
		else if (field_start)
			field_odd <= ~field_odd;
	end

	// phase reset is an event, so it is not held back to the line boundary
	always_ff @(posedge clk)
	begin
		if (reset)
			subcarrier_phase_reset <= 1'b0;
		else
			subcarrier_phase_reset <= real_time_control_input_phase_reset && rt_phase_reset_enable;
	end

	evb_pi_serializer #(
		.BITS(`EVB_PI_BITS)
	) u_pi_ser (
		.clk(clk),
		.reset(reset),
		.insert_enable(program_info_insert_enable),
		.window_start(pi_window_start),
		.bit_strobe(pi_bit_strobe),
		.payload({program_info_byte_14, program_info_byte_13, program_info_byte_12}),
		.data_bit(pi_data_bit),
		.data_valid(pi_data_valid),
		.state()
	);
endmodule

// file: sim/evb_regs_monitor.sv
`timescale 1ns/100ps
module evb_regs_monitor (
	input wire logic clk,
	input wire logic reset,
	input wire logic reg_rd_en,
	input wire logic [7:0] reg_subaddr,
	input wire evb_pkg::evb_byte_t reg_rd_data,
	input wire logic reg_rd_valid,
	input wire logic reg_hit,
	input wire logic line_start,
	input wire logic field_start,
	input wire logic real_time_control_input_field_valid,
	input wire logic real_time_control_input_phase_reset,
	input wire logic pi_bit_strobe,
	input wire evb_pkg::evb_byte_t subcarrier_phase_out,
	input wire evb_pkg::evb_gain_t u_chroma_gain_out,
	input wire evb_pkg::evb_gain_t v_chroma_gain_out,
	input wire evb_pkg::evb_level_t black_level_out,
	input wire evb_pkg::evb_level_t blanking_level_out,
	input wire logic field_odd,
	input wire logic subcarrier_phase_reset,
	input wire logic pi_data_valid
);
	import evb_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	sequence rd_req; reg_rd_en; endsequence
	sequence rd_miss; reg_rd_en && !reg_hit; endsequence
	sequence field_quiet; !real_time_control_input_field_valid && !field_start; endsequence
	sequence field_tick; field_start && !real_time_control_input_field_valid; endsequence
	field_hold_a: assert property (field_quiet |=> $stable(field_odd))
		else $error("field bit moved without cause");
	field_toggle_a: assert property (field_tick |=> field_odd != $past(field_odd))
		else $error("field bit did not toggle");
	rd_hold_a: assert property (!reg_rd_en |=> $stable(reg_rd_data))
		else $error("read data moved without a read");
	rd_valid_a: assert property (rd_req |=> reg_rd_valid)
		else $error("read not answered");
	rd_quiet_a: assert property (!reg_rd_en |=> !reg_rd_valid)
		else $error("read valid without request");
	hit_map_a: assert property (reg_hit == (reg_subaddr >= 8'h57 && reg_subaddr <= 8'h5E))
		else $error("hit flag wrong");
	unmapped_rd_a: assert property (rd_miss |=> reg_rd_data == 8'h00)
		else $error("unmapped read not zero");
	// settings must never move mid-line, whatever the register writes do
	shadow_hold_a: assert property (!line_start |=> $stable({u_chroma_gain_out,
		v_chroma_gain_out, subcarrier_phase_out, black_level_out, blanking_level_out}))
		else $error("settings changed mid-line");
	phase_quiet_a: assert property (!real_time_control_input_phase_reset |=> !subcarrier_phase_reset)
		else $error("phase reset without cause");
	pi_quiet_a: assert property (!pi_bit_strobe |=> !pi_data_valid)
		else $error("data valid without strobe");
	field_cause_a: assert property ($changed(field_odd) |-> $past(real_time_control_input_field_valid) || $past(field_start))
		else $error("field bit changed without cause");
endmodule

// file: sim/evb_regs_tb.sv
`timescale 1ns/100ps
module evb_regs_tb;
	import evb_pkg::*;
	logic clk, reset, wr, rd, ins, ls, fs, pws, pbs, rfv, rfo, rpr, rv, hit, fo, spr, pdb, pdv;
	logic [7:0] sub, wd;
	evb_byte_t rdd, ph;
	evb_gain_t ug, vg;
	evb_level_t bl, bn;
	int n_mismatch = 0;
	int num_checks = 0;
	// subaddress, write byte, expected readback; the last two are unmapped
	logic [23:0] rows [14] = '{24'h5796_96, 24'h583C_3C, 24'h59E1_E1, 24'h5A0F_0F, 24'h5A3A_3A,
		24'h5A35_35, 24'h5A57_57, 24'h5B76_76, 24'h5B7D_7D, 24'h5CAF_AF, 24'h5DFA_FA,
		24'h5EEE_EE, 24'h6055_00, 24'h5655_00};
	logic [23:0] pi_exp = 24'hE13C_96;
	evb_regs u_dut (.clk(clk), .reset(reset), .reg_wr_en(wr), .reg_rd_en(rd), .reg_subaddr(sub),
		.reg_wr_data(wd), .reg_rd_data(rdd), .reg_rd_valid(rv), .reg_hit(hit),
		.program_info_insert_enable(ins), .line_start(ls), .field_start(fs), .pi_window_start(pws),
		.pi_bit_strobe(pbs), .real_time_control_input_field_valid(rfv), .real_time_control_input_field_odd(rfo), .real_time_control_input_phase_reset(rpr),
		.subcarrier_phase_out(ph), .u_chroma_gain_out(ug), .v_chroma_gain_out(vg),
		.black_level_out(bl), .blanking_level_out(bn), .field_odd(fo),
		.subcarrier_phase_reset(spr), .pi_data_bit(pdb), .pi_data_valid(pdv));
	initial
	begin
		clk = 0;
		forever #2.5 clk = ~clk;
	end
	task print_verdict();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task chk(input logic [8:0] got, input logic [8:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic pulse(ref logic s);
		s = 1;
		tick(1);
		s = 0;
	endtask
	task wr_reg(input logic [7:0] a, input logic [7:0] d);
		sub = a;
		wd = d;
		wr = 1;
		tick(1);
		wr = 0;
		tick(1);
	endtask
	task rd_reg(input logic [7:0] a, input logic [7:0] e);
		sub = a;
		rd = 1;
		tick(1);
		rd = 0;
		chk(9'(rv), 9'h001);
		chk(9'(rdd), 9'(e));
		chk(9'(hit), 9'(a >= 8'h57 && a <= 8'h5E));
		tick(1);
	endtask
	task rt_pulse();
		rfo = 0;
		rfv = 1;
		fs = 1;
		rpr = 1;
		tick(1);
		{rfv, fs, rpr} = 3'h0;
	endtask
	initial
	begin
		#100000;
		n_mismatch++;
		print_verdict();
	end
	initial
	begin
		{wr, rd, ins, ls, fs, pws, pbs, rfv, rfo, rpr, sub, wd} = '0;
		reset = 1;
		tick(4);
		reset = 0;
		chk(9'(fo), 9'h001);
		pulse(fs);
		chk(9'(fo), 9'h000);
		for (int a = 'h57; a <= 'h5E; a++) rd_reg(8'(a), 8'h00);
		foreach (rows[i])
		begin
			wr_reg(rows[i][23:16], rows[i][15:8]);
			rd_reg(rows[i][23:16], rows[i][7:0]);
		end
		chk(9'(ph), 9'h000);
		pulse(ls);
		chk(9'(ph), 9'h057);
		chk(ug, 9'h17D);
		chk(vg, 9'h1AF);
		chk(9'(bl), 9'h03A);
		chk(9'(bn), 9'h02E);
		rt_pulse();
		chk(9'(fo), 9'h000);
		chk(9'(spr), 9'h001);
		wr_reg(8'h5D, 8'h3A);
		wr_reg(8'h5E, 8'h2E);
		wr_reg(8'h5B, 8'h00);
		wr_reg(8'h5C, 8'h00);
		pulse(ls);
		chk(ug, 9'h000);
		chk(vg, 9'h000);
		rt_pulse();
		chk(9'(fo), 9'h001);
		chk(9'(spr), 9'h000);
		ins = 1;
		pulse(pws);
		pbs = 1;
		for (int i = 0; i < 24; i++)
		begin
			tick(1);
			chk(9'(pdv), 9'h001);
			chk(9'(pdb), 9'(pi_exp[i]));
		end
		pbs = 0;
		tick(2);
		ins = 0;
		pulse(pws);
		pulse(pbs);
		chk(9'(pdv), 9'h000);
		pulse(fs);
		chk(9'(fo), 9'h000);
		reset = 1;
		tick(2);
		reset = 0;
		rd_reg(8'h57, 8'h00);
		chk(9'(ph), 9'h000);
		chk(9'(fo), 9'h001);
		print_verdict();
	end
endmodule
bind evb_regs evb_regs_monitor u_mon (.clk(clk), .reset(reset), .reg_rd_en(reg_rd_en),
	.reg_subaddr(reg_subaddr), .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid),
	.reg_hit(reg_hit), .line_start(line_start), .field_start(field_start),
	.real_time_control_input_field_valid(real_time_control_input_field_valid), .real_time_control_input_phase_reset(real_time_control_input_phase_reset),
	.pi_bit_strobe(pi_bit_strobe), .subcarrier_phase_out(subcarrier_phase_out),
	.u_chroma_gain_out(u_chroma_gain_out), .v_chroma_gain_out(v_chroma_gain_out),
	.black_level_out(black_level_out), .blanking_level_out(blanking_level_out),
	.field_odd(field_odd), .subcarrier_phase_reset(subcarrier_phase_reset),
	.pi_data_valid(pi_data_valid));
